// >>> rtl/oag_pkg.sv
// operand address generator package: modes, register codes, field positions, reset values
// assumes an 8-bit core with 16-bit addresses and little-endian instruction operands
package oag_pkg;

  // --------------------------------------------------------------------------
  // widths
  // --------------------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 16;

  // --------------------------------------------------------------------------
  // addressing modes
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    OAG_MODE_NONE,
    OAG_MODE_IMM,
    OAG_MODE_IMM_EXT,
    OAG_MODE_RESTART,
    OAG_MODE_RELATIVE,
    OAG_MODE_EXTENDED,
    OAG_MODE_INDEXED,
    OAG_MODE_REGISTER,
    OAG_MODE_IMPLIED,
    OAG_MODE_REG_IND,
    OAG_MODE_BLOCK
  } oag_mode_t;

  // pointer pair selector for register indirect access
  typedef enum logic [1:0] {
    OAG_PAIR_BC,
    OAG_PAIR_DE,
    OAG_PAIR_PTR,
    OAG_PAIR_SP
  } oag_pair_t;

  // --------------------------------------------------------------------------
  // 8-bit register codes as carried in opcode fields
  // --------------------------------------------------------------------------
  localparam logic [2:0] REG_B    = 3'h0;
  localparam logic [2:0] REG_C    = 3'h1;
  localparam logic [2:0] REG_D    = 3'h2;
  localparam logic [2:0] REG_E    = 3'h3;
  localparam logic [2:0] REG_H    = 3'h4;
  localparam logic [2:0] REG_L    = 3'h5;
  localparam logic [2:0] REG_MEM  = 3'h6;
  localparam logic [2:0] REG_ACC  = 3'h7;

  // --------------------------------------------------------------------------
  // opcode field positions
  // --------------------------------------------------------------------------
  localparam int unsigned SRC_LSB = 0;
  localparam int unsigned DST_LSB = 3;
  localparam int unsigned BIT_LSB = 3;
  localparam int unsigned RST_LSB = 3;
  localparam int unsigned FLD_W   = 3;
  localparam int unsigned RST_SHIFT = 3;

  // --------------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------------
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0]  DATA_RST = 8'h00;

endpackage : oag_pkg

// >>> rtl/oag_adder.sv
// 16-bit wrapping address adder with signed 8-bit offset
// assumes purely combinational use inside the generator
module oag_adder (
  input  wire logic [15:0] base,
  input  wire logic [7:0]  offset,
  output logic      [15:0] sum
);
  import oag_pkg::*;

  // sign extension then modulo 65536 add, no carry out kept on purpose
  assign sum = base + {{8{offset[7]}}, offset};

endmodule : oag_adder

// >>> rtl/oag_core.sv
// operand and effective address generator for an 8-bit core
// assumes instruction bytes are presented already fetched, synchronous to clock
module oag_core (
  input  wire logic              clock,
  input  wire logic              rst,
  // request
  input  wire logic              start,
  input  wire oag_pkg::oag_mode_t src_mode,
  input  wire oag_pkg::oag_mode_t dst_mode,
  input  wire logic [7:0]        opcode,
  input  wire logic [7:0]        byte1,
  input  wire logic [7:0]        byte2,
  input  wire logic [15:0]       opcode_addr,
  input  wire logic [1:0]        opcode_len,
  input  wire logic              index_sel,
  input  wire oag_pkg::oag_pair_t pair_sel,
  input  wire logic              word_op,
  input  wire logic              word_high,
  input  wire logic              block_dec,
  input  wire logic [7:0]        block_key,
  input  wire logic [7:0]        block_data,
  // register state
  input  wire logic [15:0]       index_reg_first,
  input  wire logic [15:0]       index_reg_second,
  input  wire logic [15:0]       pointer_pair,
  input  wire logic [15:0]       pair_bc,
  input  wire logic [15:0]       pair_de,
  input  wire logic [15:0]       pair_sp,
  // results
  output logic                   done,
  output logic [7:0]             src_value,
  output logic [15:0]            word_value,
  output logic [15:0]            src_addr,
  output logic                   src_mem,
  output logic [15:0]            dst_addr,
  output logic                   dst_mem,
  output logic [2:0]             src_reg,
  output logic [2:0]             dst_reg,
  output logic [15:0]            jump_target,
  output logic                   jump_valid,
  output logic [2:0]             bit_sel,
  output logic [7:0]             bit_mask,
  output logic [15:0]            next_ptr_src,
  output logic [15:0]            next_ptr_dst,
  output logic                   block_match
);
  import oag_pkg::*;

  // --------------------------------------------------------------------------
  // operand byte placement
  // --------------------------------------------------------------------------
  logic [15:0] word_imm;
  logic [7:0]  disp;
  logic [7:0]  imm_byte;
  logic        dst_indexed;

  assign dst_indexed = (dst_mode == OAG_MODE_INDEXED);
  // low byte comes first in the stream
  assign word_imm = {byte2, byte1};
  // displacement sits right after the opcode, data follows it
  assign disp     = byte1;
  assign imm_byte = (dst_indexed || src_mode == OAG_MODE_INDEXED) ? byte2 : byte1;

  // --------------------------------------------------------------------------
  // address arithmetic
  // --------------------------------------------------------------------------
  logic [15:0] index_base;
  logic [15:0] index_addr;
  logic [15:0] next_pc;
  logic [15:0] rel_target;
  logic [15:0] pair_addr;
  logic [15:0] pair_hi_addr;
  logic [15:0] step_src;
  logic [15:0] step_dst;
  logic [15:0] restart_addr;

  // index register is only read, never written here
  assign index_base = index_sel ? index_reg_second : index_reg_first;

  oag_adder u_index_add (
    .base   (index_base),
    .offset (disp),
    .sum    (index_addr)
  );

  // next opcode address: opcode + 2 for a two-byte jump
  assign next_pc = opcode_addr + {14'h0000, opcode_len};

  oag_adder u_rel_add (
    .base   (next_pc),
    .offset (byte1),
    .sum    (rel_target)
  );

  always_comb begin
    unique case (pair_sel)
      OAG_PAIR_BC:  pair_addr = pair_bc;
      OAG_PAIR_DE:  pair_addr = pair_de;
      OAG_PAIR_PTR: pair_addr = pointer_pair;
      OAG_PAIR_SP:  pair_addr = pair_sp;
    endcase
  end

  // high half of a word operand at the next address
  assign pair_hi_addr = pair_addr + 16'h0001;

  // block pointers step by one either way, wrapping
  assign step_src = block_dec ? pointer_pair - 16'h0001 : pointer_pair + 16'h0001;
  assign step_dst = block_dec ? pair_de - 16'h0001 : pair_de + 16'h0001;

  // selector times eight keeps the target inside page zero
  assign restart_addr = {10'h000, opcode[RST_LSB +: FLD_W], 3'h0};

  // --------------------------------------------------------------------------
  // per-side address and memory flag, one function for both sides
  // --------------------------------------------------------------------------
  function automatic logic [16:0] side_addr(input oag_mode_t m);
    logic [16:0] r;
    r = {1'b0, ADDR_RST};
    unique case (m)
      OAG_MODE_EXTENDED: r = {1'b1, word_imm};
      OAG_MODE_INDEXED:  r = {1'b1, index_addr};
      OAG_MODE_REG_IND:  r = {1'b1, word_high ? pair_hi_addr : pair_addr};
      OAG_MODE_BLOCK:    r = {1'b1, pair_addr};
      OAG_MODE_REGISTER: r = (opcode[2:0] == REG_MEM) ? {1'b1, pointer_pair} : r;
      default:           r = {1'b0, ADDR_RST};
    endcase
    return r;
  endfunction : side_addr

  logic [16:0] next_src;
  logic [16:0] next_dst;
  logic [15:0] next_block_dst;

  // a process, not an assign: the function reads operand bytes and pairs beyond its argument
  always_comb begin
    next_src = side_addr(src_mode);
    next_dst = side_addr(dst_mode);
  end

  assign next_block_dst = pair_de;

  // --------------------------------------------------------------------------
  // register fields
  // --------------------------------------------------------------------------
  logic [2:0] next_src_reg;
  logic [2:0] next_dst_reg;

  always_comb begin
    next_src_reg = opcode[SRC_LSB +: FLD_W];
    next_dst_reg = opcode[DST_LSB +: FLD_W];
    if (dst_mode == OAG_MODE_IMPLIED) begin
      next_dst_reg = REG_ACC;
    end
    if (src_mode == OAG_MODE_IMPLIED) begin
      next_src_reg = REG_ACC;
    end
  end

  // --------------------------------------------------------------------------
  // result registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
    end else begin
      done <= start;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      src_value <= DATA_RST;
    end else if (start) begin
      src_value <= (src_mode == OAG_MODE_IMM) ? imm_byte : DATA_RST;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      word_value <= ADDR_RST;
    end else if (start) begin
      word_value <= (src_mode == OAG_MODE_IMM_EXT) ? word_imm : ADDR_RST;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      src_addr <= ADDR_RST;
      src_mem  <= 1'b0;
    end else if (start) begin
      src_addr <= next_src[15:0];
      src_mem  <= next_src[16];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dst_addr <= ADDR_RST;
      dst_mem  <= 1'b0;
    end else if (start) begin
      // block destination pointer rides in the second pair
      dst_addr <= (src_mode == OAG_MODE_BLOCK) ? next_block_dst : next_dst[15:0];
      dst_mem  <= (src_mode == OAG_MODE_BLOCK) ? 1'b1 : next_dst[16];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      src_reg <= REG_B;
    end else if (start) begin
      src_reg <= next_src_reg;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dst_reg <= REG_B;
    end else if (start) begin
      dst_reg <= next_dst_reg;
    end
  end

  // --------------------------------------------------------------------------
  // jump target
  // --------------------------------------------------------------------------
  logic [15:0] next_jump_target;
  logic        next_jump_valid;

  // only the three jump modes raise the strobe; any other mode parks the target at zero
  always_comb begin
    next_jump_target = ADDR_RST;
    next_jump_valid  = 1'b1;
    unique case (src_mode)
      OAG_MODE_RESTART:  next_jump_target = restart_addr;
      OAG_MODE_RELATIVE: next_jump_target = rel_target;
      OAG_MODE_EXTENDED: next_jump_target = word_imm;
      default:           next_jump_valid  = 1'b0;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      jump_target <= ADDR_RST;
    end else if (start) begin
      jump_target <= next_jump_target;
    end
  end

  // strobe lasts one cycle so a held target is never taken twice
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      jump_valid <= 1'b0;
    end else begin
      jump_valid <= start && next_jump_valid;
    end
  end

  // --------------------------------------------------------------------------
  // bit selection
  // --------------------------------------------------------------------------
  logic [7:0] next_mask;

  for (genvar i = 0; i < 8; i++) begin : g_mask
    assign next_mask[i] = (opcode[BIT_LSB +: FLD_W] == 3'(i));
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bit_sel <= 3'h0;
    end else if (start) begin
      bit_sel <= opcode[BIT_LSB +: FLD_W];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bit_mask <= DATA_RST;
    end else if (start) begin
      bit_mask <= next_mask;
    end
  end

  // --------------------------------------------------------------------------
  // block move and search stepping
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      next_ptr_src <= ADDR_RST;
    end else if (start) begin
      next_ptr_src <= step_src;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      next_ptr_dst <= ADDR_RST;
    end else if (start) begin
      next_ptr_dst <= step_dst;
    end
  end

  // compare only meaningful in block mode; other modes leave it low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      block_match <= 1'b0;
    end else if (start) begin
      block_match <= (src_mode == OAG_MODE_BLOCK) && (block_data == block_key);
    end
  end

endmodule : oag_core

// >>> test/oag_core_properties.sv
// ----------------------------------------------------------------------------
// timed checks on the operand address generator ports
// ----------------------------------------------------------------------------
// assumes it is bound to oag_core and sees only that module's ports
module oag_core_props (
  input wire logic               clock,
  input wire logic               rst,
  input wire logic               start,
  input wire oag_pkg::oag_mode_t src_mode,
  input wire oag_pkg::oag_mode_t dst_mode,
  input wire logic [7:0]         opcode,
  input wire logic [7:0]         byte1,
  input wire logic [7:0]         byte2,
  input wire logic [15:0]        opcode_addr,
  input wire logic [1:0]         opcode_len,
  input wire logic               index_sel,
  input wire logic [15:0]        index_reg_first,
  input wire logic [15:0]        index_reg_second,
  input wire logic               done,
  input wire logic [15:0]        word_value,
  input wire logic [15:0]        src_addr,
  input wire logic               src_mem,
  input wire logic [2:0]         dst_reg,
  input wire logic [15:0]        jump_target,
  input wire logic               jump_valid,
  input wire logic [2:0]         bit_sel,
  input wire logic [7:0]         bit_mask
);
  timeunit 1ns;
  timeprecision 1ps;
  import oag_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // helper copies of the request; sums held here since $past takes a signal only
  logic [7:0]  op_q;
  logic [15:0] rel_exp;
  logic [15:0] idx_exp;
  always_ff @(posedge clock) begin
    op_q    <= opcode;
    rel_exp <= opcode_addr + {14'h0000, opcode_len} + {{8{byte1[7]}}, byte1};
    idx_exp <= (index_sel ? index_reg_second : index_reg_first) + {{8{byte1[7]}}, byte1};
  end
  property p_done; start |=> done; endproperty
  property p_hold; !start |=> !done && !jump_valid && $stable(src_addr); endproperty
  property p_word;
    start && src_mode == OAG_MODE_IMM_EXT |=> word_value == {$past(byte2), $past(byte1)};
  endproperty
  property p_rst;
    start && src_mode == OAG_MODE_RESTART |=> jump_valid && jump_target == {10'h000, op_q[5:3], 3'h0};
  endproperty
  property p_rel; start && src_mode == OAG_MODE_RELATIVE |=> jump_valid && jump_target == rel_exp;
  endproperty
  property p_idx; start && src_mode == OAG_MODE_INDEXED |=> src_mem && src_addr == idx_exp;
  endproperty
  property p_bit; done |-> bit_mask == (8'h01 << bit_sel) && bit_sel == op_q[5:3]; endproperty
  property p_impl; start && dst_mode == OAG_MODE_IMPLIED |=> dst_reg == REG_ACC; endproperty
  a_done: assert property (p_done) else $error("no done after request");
  a_hold: assert property (p_hold) else $error("outputs moved without request");
  a_word: assert property (p_word) else $error("word operand wrong");
  a_rst: assert property (p_rst) else $error("restart target wrong");
  a_rel: assert property (p_rel) else $error("relative target wrong");
  a_idx: assert property (p_idx) else $error("indexed address wrong");
  a_bit: assert property (p_bit) else $error("bit select wrong");
  a_impl: assert property (p_impl) else $error("implied target wrong");
  c_b2b: cover property (start ##1 start);
  c_neg: cover property (start && src_mode == OAG_MODE_RELATIVE && byte1 == 8'h80);
  c_idx: cover property (start && src_mode == OAG_MODE_INDEXED && index_sel);
endmodule : oag_core_props

// >>> test/oag_fetch_model.sv
// ----------------------------------------------------------------------------
// instruction byte store: hands out the two bytes that follow an opcode
// ----------------------------------------------------------------------------
// assumes the bench loads every location through the write port before use
module oag_fetch_model (
  input wire logic        clock,
  input wire logic        we,
  input wire logic [7:0]  wa,
  input wire logic [7:0]  wd,
  input wire logic [15:0] pc,
  output logic      [7:0] byte1,
  output logic      [7:0] byte2
);
  timeunit 1ns;
  timeprecision 1ps;
  // small store only: the page offset of pc selects, so code wraps every 256 bytes
  logic [7:0] mem [256];
  always_ff @(posedge clock) begin
    if (we) begin
      mem[wa] <= wd;
    end
  end
  // displacement or low half first, then data or high half
  assign byte1 = mem[pc[7:0] + 8'h01];
  assign byte2 = mem[pc[7:0] + 8'h02];
endmodule : oag_fetch_model

// >>> test/tb_oag_core.sv
// ----------------------------------------------------------------------------
// self-checking bench for the operand address generator
// ----------------------------------------------------------------------------
// assumes the fetch model supplies operand bytes and the bench mirrors its store
module tb_oag_core;
  timeunit 1ns;
  timeprecision 1ps;
  import oag_pkg::*;
  `define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
    $display("[FAIL] %0t got %h want %h", $time, (a), (b)); end end
  logic clock = 1'b0, rst = 1'b1, start = 1'b0, index_sel = 1'b0, word_high = 1'b0;
  logic block_dec = 1'b0, we = 1'b0, done, src_mem, dst_mem, jump_valid, block_match;
  oag_mode_t src_mode = OAG_MODE_NONE, dst_mode = OAG_MODE_NONE;
  oag_pair_t pair_sel = OAG_PAIR_BC;
  logic [7:0]  opcode = 8'h00, block_key = 8'h00, block_data = 8'h00, wa = 8'h00, wd = 8'h00;
  logic [7:0]  byte1, byte2, src_value, bit_mask, shadow [256];
  logic [15:0] opcode_addr = 16'h0000, idx_a = 16'h0000, idx_b = 16'h0000, ptr = 16'h0000;
  logic [15:0] bc = 16'h0000, de = 16'h0000, sp = 16'h0000;
  logic [15:0] word_value, src_addr, dst_addr, jump_target, next_ptr_src, next_ptr_dst;
  logic [2:0]  src_reg, dst_reg, bit_sel;
  logic [31:0] rs = 32'h0000_0008, r;
  int          err_total = 0, tests_run = 0;
  always #5 clock = ~clock;
  oag_fetch_model fetch_u (.clock(clock), .we(we), .wa(wa), .wd(wd), .pc(opcode_addr),
    .byte1(byte1), .byte2(byte2));
  // opcode_len fixed at two: only two-byte relative jumps are driven
  oag_core dut_u (.clock(clock), .rst(rst), .start(start), .src_mode(src_mode),
    .dst_mode(dst_mode), .opcode(opcode), .byte1(byte1), .byte2(byte2),
    .opcode_addr(opcode_addr), .opcode_len(2'h2), .index_sel(index_sel), .pair_sel(pair_sel),
    .word_op(1'b0), .word_high(word_high), .block_dec(block_dec), .block_key(block_key),
    .block_data(block_data), .index_reg_first(idx_a), .index_reg_second(idx_b),
    .pointer_pair(ptr), .pair_bc(bc), .pair_de(de), .pair_sp(sp), .done(done),
    .src_value(src_value), .word_value(word_value), .src_addr(src_addr), .src_mem(src_mem),
    .dst_addr(dst_addr), .dst_mem(dst_mem), .src_reg(src_reg), .dst_reg(dst_reg),
    .jump_target(jump_target), .jump_valid(jump_valid), .bit_sel(bit_sel),
    .bit_mask(bit_mask), .next_ptr_src(next_ptr_src), .next_ptr_dst(next_ptr_dst),
    .block_match(block_match));
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : xs
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  task automatic issue(input oag_mode_t sm, input oag_mode_t dm, input logic [7:0] op,
                       input logic [15:0] pc);
    logic [7:0]  b1, b2;
    logic [15:0] d, ix, pr;
    b1 = shadow[pc[7:0] + 8'h01];
    b2 = shadow[pc[7:0] + 8'h02];
    @(posedge clock);
    r = xs();
    start <= 1'b1; src_mode <= sm; dst_mode <= dm; opcode <= op; opcode_addr <= pc;
    index_sel <= r[0]; word_high <= r[1]; pair_sel <= oag_pair_t'(r[3:2]); block_dec <= r[4];
    block_key <= r[15:8]; block_data <= r[5] ? r[15:8] : r[23:16];
    r = xs(); idx_a <= r[15:0]; idx_b <= r[31:16];
    r = xs(); ptr <= r[15:0]; de <= r[31:16];
    r = xs(); bc <= r[15:0]; sp <= r[31:16];
    @(posedge clock);
    start <= 1'b0;
    #1;
    d  = {{8{b1[7]}}, b1};
    ix = index_sel ? idx_b : idx_a;
    pr = pair_sel == OAG_PAIR_BC ? bc : pair_sel == OAG_PAIR_DE ? de
       : pair_sel == OAG_PAIR_PTR ? ptr : sp;
    `CHK(done, 1'b1)
    `CHK(bit_mask, 8'h01 << op[5:3])
    `CHK(dst_reg, dm == OAG_MODE_IMPLIED ? REG_ACC : op[5:3])
    `CHK(src_reg, sm == OAG_MODE_IMPLIED ? REG_ACC : op[2:0])
    `CHK(jump_valid, sm inside {OAG_MODE_RESTART, OAG_MODE_RELATIVE, OAG_MODE_EXTENDED})
    if (sm == OAG_MODE_BLOCK) `CHK({dst_mem, dst_addr}, {1'b1, de})
    else if (dm == OAG_MODE_INDEXED) `CHK({dst_mem, dst_addr}, {1'b1, ix + d})
    case (sm)
      OAG_MODE_IMM: `CHK(src_value, dm == OAG_MODE_INDEXED ? b2 : b1)
      OAG_MODE_IMM_EXT: `CHK(word_value, {b2, b1})
      OAG_MODE_RESTART: `CHK(jump_target, {10'h000, op[5:3], 3'h0})
      OAG_MODE_RELATIVE: `CHK(jump_target, pc + 16'h0002 + d)
      OAG_MODE_EXTENDED: `CHK({src_mem, src_addr, jump_target}, {1'b1, b2, b1, b2, b1})
      OAG_MODE_INDEXED: `CHK({src_mem, src_addr}, {1'b1, ix + d})
      OAG_MODE_REG_IND: `CHK({src_mem, src_addr}, {1'b1, pr + {15'h0000, word_high}})
      OAG_MODE_REGISTER: `CHK({src_mem, src_addr}, op[2:0] == REG_MEM ? {1'b1, ptr} : 17'h00000)
      OAG_MODE_BLOCK: `CHK({block_match, src_addr, next_ptr_src, next_ptr_dst},
        {block_key == block_data, pr, block_dec ? ptr - 16'h0001 : ptr + 16'h0001,
         block_dec ? de - 16'h0001 : de + 16'h0001})
      default: ;
    endcase
  endtask : issue
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    // fixed displacement corners at 0x01, 0x11 and 0xff, random bytes elsewhere
    for (int i = 0; i < 256; i++) begin
      @(posedge clock);
      r = xs();
      shadow[i] = (i == 1 || i == 255) ? 8'h7f : (i == 17) ? 8'h80 : r[7:0];
      we <= 1'b1; wa <= i[7:0]; wd <= shadow[i];
    end
    @(posedge clock);
    we <= 1'b0;
    issue(OAG_MODE_RELATIVE, OAG_MODE_NONE, 8'h18, 16'h1000);
    issue(OAG_MODE_RELATIVE, OAG_MODE_NONE, 8'h18, 16'h1010);
    issue(OAG_MODE_RELATIVE, OAG_MODE_NONE, 8'h18, 16'hfffe);
    for (int k = 0; k < 8; k++) issue(OAG_MODE_RESTART, OAG_MODE_NONE, {2'h3, k[2:0], 3'h7}, 16'h2000);
    $display("test corners finished");
    for (int n = 0; n < 400; n++) begin
      r = xs();
      issue(oag_mode_t'(4'(r[7:0] % 8'h0b)), oag_mode_t'(4'(r[15:8] % 8'h0b)), r[23:16],
            16'(xs()));
    end
    $display("test random finished");
    // reset in mid-run clears done, jump_valid, jump_target and src_addr
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    `CHK({done, jump_valid, jump_target, src_addr}, 34'h000000000)
    rst <= 1'b0;
    issue(OAG_MODE_INDEXED, OAG_MODE_IMPLIED, 8'h86, 16'h0010);
    $display("test reset finished");
    final_report();
  end
  initial begin
    #60000;
    err_total++;
    final_report();
  end
endmodule : tb_oag_core
bind oag_core oag_core_props u_props (.clock(clock), .rst(rst), .start(start),
  .src_mode(src_mode), .dst_mode(dst_mode), .opcode(opcode), .byte1(byte1), .byte2(byte2),
  .opcode_addr(opcode_addr), .opcode_len(opcode_len), .index_sel(index_sel),
  .index_reg_first(index_reg_first), .index_reg_second(index_reg_second), .done(done),
  .word_value(word_value), .src_addr(src_addr), .src_mem(src_mem), .dst_reg(dst_reg),
  .jump_target(jump_target), .jump_valid(jump_valid), .bit_sel(bit_sel), .bit_mask(bit_mask));
